/* rtl/tcm_pkg.sv */
/*
 Constants for the tandem monitor defect logic: register map, reset values,
 overhead byte fields and frame counts. Assumes one clock domain.
*/
package tcm_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DEG_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PM = 8'h0C;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_SUP_BIT = 0;
    localparam int CTRL_TRACE_CHECK_DISABLE_BIT = 1;
    localparam int CTRL_SSF_REP_BIT = 2;
    localparam int CTRL_RDI_REP_BIT = 3;
    localparam int CTRL_ODI_REP_BIT = 4;
    localparam int CTRL_AIS_REP_BIT = 5;
    localparam logic [15:0] DEG_THR_RESET = 16'h0000_0001;
    localparam logic [3:0] DEG_M_RESET = 4'h0003;
    localparam logic [3:0] IEC_ALARM_CODE = 4'h000E;
    localparam logic [7:0] UNEQ_CODE = 8'h0000;
    localparam logic [11:0] MF_PATTERN = 12'h0FFE;
    localparam int MF_LEN = 76;
    localparam logic [6:0] RDI_PHASE = 7'h0043;
    localparam logic [6:0] ODI_PHASE = 7'h0044;
    localparam logic [2:0] FILT_FRAMES = 3'h0005;
endpackage

/* rtl/tcm_monitor.sv */
/*
 Tandem monitor defect detection, correlation and per-second accounting,
 with an AHB-Lite register slave. Assumes frame_start, overhead byte, parity
 count, trace mismatch and one_second come from logic on clk.
*/
// Register access over AHB-Lite and the address map are this design's own decisions.
// Operation
// - Tandem loss follows out-of-multiframe state
// - Trace mismatch raised and cleared within 1 s
// - Trace mismatch held off during server fail
// - Disable bit in the control register blocks trace mismatch
// - Quality drop from parity violation counts
// - Remote defect filtered from recovered bit
// - Outgoing defect filtered the same way
// - Alarm raised after five alarm-code frames
// - Alarm cleared after five other-code frames
// - Only code 1110 means alarm present
// - Trail fail and degrade from defects
// - Tandem loss report gating
// - Trace mismatch report gating
// - Quality drop report gating
// - Unequipped and server fail report gating
// - Remote defect report gating
// - Outgoing defect report gating
// - Incoming alarm report gating
// - Per-second defect seconds and block totals
// - Two bad words lose, one good regains
// - Search and check alignment pattern
// - Errored block when parity and code differ
// - Unequipped after five zero bytes, five clear
`timescale 1ns/10ps
module tcm_monitor #(
    parameter int PM_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frame_start,
    input wire logic [7:0] tandem_overhead_byte,
    input wire logic [3:0] parity_error_count,
    input wire logic trace_mismatch_raw,
    input wire logic server_signal_fail_in,
    input wire logic one_second,
    output logic trail_signal_fail,
    output logic trail_signal_degrade,
    output logic reported_unequipped,
    output logic reported_tandem_loss,
    output logic reported_trace_mismatch,
    output logic reported_quality_drop,
    output logic reported_server_fail,
    output logic reported_remote_defect,
    output logic reported_outgoing_defect,
    output logic reported_incoming_alarm,
    output logic near_defect_second,
    output logic far_defect_second,
    output logic [PM_WIDTH-1:0] near_errored_block_count
);
    import tcm_pkg::*;

    // Count field in the PM word is 16 bits wide
    if (PM_WIDTH < 4 || PM_WIDTH > 16) begin : g_bad_width
        $error("PM_WIDTH must be 4 to 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register slave, zero wait states
    logic [7:0] ctrl_reg;
    logic [15:0] deg_thr_reg;
    logic [3:0] deg_m_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic supervision_on;
    logic trace_check_disable;
    logic tandem_loss_defect;
    logic trace_mismatch_defect;
    logic quality_drop_defect;
    logic remote_defect;
    logic outgoing_defect;
    logic incoming_alarm_defect;
    logic unequipped_defect;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign supervision_on = ctrl_reg[CTRL_SUP_BIT];
    assign trace_check_disable = ctrl_reg[CTRL_TRACE_CHECK_DISABLE_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0000;
        end else begin
            wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            deg_thr_reg <= DEG_THR_RESET;
            deg_m_reg <= DEG_M_RESET;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                ADDR_CTRL: ctrl_reg <= hwdata[7:0];
                ADDR_DEG_CFG: begin
                    deg_thr_reg <= hwdata[15:0];
                    deg_m_reg <= hwdata[19:16];
                end
                default: ;
            endcase
        end
    end

    // Read data registered in the address phase, so it stands in the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                ADDR_CTRL: hrdata <= {24'h00_0000, ctrl_reg};
                ADDR_DEG_CFG: hrdata <= {12'h000, deg_m_reg, deg_thr_reg};
                ADDR_STATUS: hrdata <= {23'h00_0000, trail_signal_degrade,
                    trail_signal_fail, unequipped_defect, incoming_alarm_defect,
                    outgoing_defect, remote_defect, quality_drop_defect,
                    trace_mismatch_defect, tandem_loss_defect};
                ADDR_PM: hrdata <= {14'h0000, far_defect_second, near_defect_second,
                    16'(near_errored_block_count)};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiframe alignment on bits 7 and 8
    logic [9:0] mf_hist_reg;
    logic [6:0] mf_phase_reg;
    logic [6:0] cur_phase;
    logic oom_reg;
    logic mf_err_reg;
    logic mf_match;

    assign mf_match = ({mf_hist_reg, tandem_overhead_byte[1:0]} == MF_PATTERN);
    assign cur_phase = (mf_phase_reg == 7'(MF_LEN - 1)) ? 7'h0000 : mf_phase_reg + 7'h0001;

    always_ff @(posedge clk) begin
        if (rst) begin
            mf_hist_reg <= 10'h0000;
            mf_phase_reg <= 7'h0000;
            oom_reg <= 1'b1;
            mf_err_reg <= 1'b0;
        end else if (frame_start) begin
            mf_hist_reg <= {mf_hist_reg[7:0], tandem_overhead_byte[1:0]};
            if (oom_reg) begin
                if (mf_match) begin
                    oom_reg <= 1'b0;
                    mf_phase_reg <= 7'h0000;
                    mf_err_reg <= 1'b0;
                end
            end else begin
                mf_phase_reg <= cur_phase;
                if (cur_phase == 7'h0000) begin
                    if (mf_match) begin
                        mf_err_reg <= 1'b0;
                    end else if (mf_err_reg) begin
                        oom_reg <= 1'b1;
                    end else begin
                        mf_err_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign tandem_loss_defect = oom_reg;

    ////////////////////////////////////////////////////////////////////////
    // Five-strobe persistence filters: unequipped, alarm per frame; remote, outgoing per multiframe
    logic [3:0] filt_in;
    logic [3:0] filt_stb;
    logic [3:0] filt_state;

    assign filt_in = {tandem_overhead_byte[1], tandem_overhead_byte[0],
        tandem_overhead_byte[7:4] == IEC_ALARM_CODE,
        tandem_overhead_byte == UNEQ_CODE};
    // Remote and outgoing bits only count once per multiframe while aligned
    assign filt_stb = {frame_start && !oom_reg && cur_phase == ODI_PHASE,
        frame_start && !oom_reg && cur_phase == RDI_PHASE,
        frame_start, frame_start};

    generate
        for (genvar i = 0; i < 4; i++) begin : g_filt
            logic [2:0] cnt_reg;
            logic state_reg;
            always_ff @(posedge clk) begin
                if (rst) begin
                    cnt_reg <= 3'h0000;
                    state_reg <= 1'b0;
                end else if (filt_stb[i]) begin
                    if (filt_in[i] == state_reg) begin
                        cnt_reg <= 3'h0000;
                    end else if (cnt_reg == FILT_FRAMES - 3'h0001) begin
                        cnt_reg <= 3'h0000;
                        state_reg <= filt_in[i];
                    end else begin
                        cnt_reg <= cnt_reg + 3'h0001;
                    end
                end
            end
            assign filt_state[i] = state_reg;
        end
    endgenerate

    assign unequipped_defect = filt_state[0];
    assign incoming_alarm_defect = filt_state[1];
    assign remote_defect = filt_state[2];
    assign outgoing_defect = filt_state[3];

    ////////////////////////////////////////////////////////////////////////
    // Trace mismatch, sampled each frame: latency far below one second
    logic tim_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            tim_reg <= 1'b0;
        end else if (server_signal_fail_in || trace_check_disable) begin
            tim_reg <= 1'b0;
        end else if (frame_start) begin
            tim_reg <= trace_mismatch_raw;
        end
    end

    assign trace_mismatch_defect = tim_reg;

    ////////////////////////////////////////////////////////////////////////
    // Errored blocks and degrade: bad second at threshold, M seconds to flip
    logic block_err;
    logic [15:0] sec_blocks_reg;
    logic [3:0] deg_cnt_reg;
    logic deg_reg;
    logic bad_second;

    assign block_err = frame_start && (parity_error_count != tandem_overhead_byte[7:4]);
    assign bad_second = (sec_blocks_reg >= deg_thr_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            sec_blocks_reg <= 16'h0000;
        end else if (one_second) begin
            sec_blocks_reg <= {15'h0000, block_err};
        end else if (block_err && sec_blocks_reg != 16'hFFFF) begin
            sec_blocks_reg <= sec_blocks_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            deg_cnt_reg <= 4'h0000;
            deg_reg <= 1'b0;
        end else if (one_second) begin
            if (bad_second == deg_reg) begin
                deg_cnt_reg <= 4'h0000;
            end else if (deg_cnt_reg + 4'h0001 >= deg_m_reg) begin
                deg_cnt_reg <= 4'h0000;
                deg_reg <= bad_second;
            end else begin
                deg_cnt_reg <= deg_cnt_reg + 4'h0001;
            end
        end
    end

    assign quality_drop_defect = deg_reg;

    ////////////////////////////////////////////////////////////////////////
    // Consequent actions and correlations, registered
    logic tsf_comb;

    assign tsf_comb = server_signal_fail_in || unequipped_defect ||
        trace_mismatch_defect || tandem_loss_defect;

    always_ff @(posedge clk) begin
        if (rst) begin
            trail_signal_fail <= 1'b0;
            trail_signal_degrade <= 1'b0;
        end else begin
            trail_signal_fail <= tsf_comb;
            trail_signal_degrade <= quality_drop_defect;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !supervision_on) begin
            reported_unequipped <= 1'b0;
            reported_tandem_loss <= 1'b0;
            reported_trace_mismatch <= 1'b0;
            reported_quality_drop <= 1'b0;
            reported_server_fail <= 1'b0;
            reported_remote_defect <= 1'b0;
            reported_outgoing_defect <= 1'b0;
            reported_incoming_alarm <= 1'b0;
        end else begin
            reported_unequipped <= unequipped_defect;
            reported_tandem_loss <= !unequipped_defect && !server_signal_fail_in &&
                tandem_loss_defect;
            reported_trace_mismatch <= !unequipped_defect && !tandem_loss_defect &&
                trace_mismatch_defect;
            reported_quality_drop <= !trace_mismatch_defect && !tandem_loss_defect &&
                quality_drop_defect;
            reported_server_fail <= server_signal_fail_in &&
                ctrl_reg[CTRL_SSF_REP_BIT];
            reported_remote_defect <= !unequipped_defect && !trace_mismatch_defect &&
                !tandem_loss_defect && remote_defect && ctrl_reg[CTRL_RDI_REP_BIT];
            reported_outgoing_defect <= !unequipped_defect && !trace_mismatch_defect &&
                !tandem_loss_defect && outgoing_defect && ctrl_reg[CTRL_ODI_REP_BIT];
            reported_incoming_alarm <= incoming_alarm_defect && !server_signal_fail_in &&
                !tandem_loss_defect && !trace_mismatch_defect &&
                ctrl_reg[CTRL_AIS_REP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-second accounting; an event in the closing cycle lands in the new second
    logic near_seen_reg;
    logic far_seen_reg;
    logic [PM_WIDTH-1:0] ebc_acc_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            near_seen_reg <= 1'b0;
            far_seen_reg <= 1'b0;
            ebc_acc_reg <= '0;
            near_defect_second <= 1'b0;
            far_defect_second <= 1'b0;
            near_errored_block_count <= '0;
        end else if (one_second) begin
            near_defect_second <= near_seen_reg;
            far_defect_second <= far_seen_reg;
            near_errored_block_count <= ebc_acc_reg;
            near_seen_reg <= tsf_comb;
            far_seen_reg <= remote_defect;
            ebc_acc_reg <= {{(PM_WIDTH - 1){1'b0}}, block_err};
        end else begin
            near_seen_reg <= near_seen_reg || tsf_comb;
            far_seen_reg <= far_seen_reg || remote_defect;
            if (block_err && !(&ebc_acc_reg)) begin
                ebc_acc_reg <= ebc_acc_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_two_bad_words;
        frame_start && !oom_reg && cur_phase == 7'h0000 && !mf_match && mf_err_reg;
    endsequence

    a_loss_holds: assert property (tandem_loss_defect && !mf_match |=> tandem_loss_defect)
        else $error("tandem loss cleared without alignment pattern");
    a_mf_two_bad: assert property (s_two_bad_words |=> oom_reg)
        else $error("alignment kept after two errored words");
    a_mf_regain: assert property (frame_start && oom_reg && mf_match |=> !oom_reg)
        else $error("alignment not regained on pattern");
    a_tim_ssf_off: assert property (server_signal_fail_in |=> !trace_mismatch_defect)
        else $error("trace mismatch during server fail");
    a_tim_disable: assert property (trace_check_disable |=> !trace_mismatch_defect)
        else $error("trace mismatch while disabled");
    a_tsf_cause: assert property (tsf_comb |=> trail_signal_fail)
        else $error("trail fail missing");
    a_sup_off_quiet: assert property (!supervision_on |=> !(reported_unequipped ||
        reported_tandem_loss || reported_server_fail || reported_incoming_alarm))
        else $error("report while supervision off");
    a_tlc_gating: assert property (reported_tandem_loss |-> $past(tandem_loss_defect)
        && !$past(unequipped_defect) && !$past(server_signal_fail_in))
        else $error("tandem loss reported without cause");
    a_alarm_gating: assert property (reported_incoming_alarm |->
        $past(incoming_alarm_defect) && !$past(trace_mismatch_defect))
        else $error("alarm reported without cause");
    a_pm_latch: assert property (one_second |=> near_errored_block_count ==
        $past(ebc_acc_reg))
        else $error("block total not latched");
    a_tim_follow: assert property (frame_start && trace_mismatch_raw &&
        !server_signal_fail_in && !trace_check_disable |=> trace_mismatch_defect)
        else $error("trace mismatch not raised");
endmodule

/* verification/tcm_frame_src.sv */
/*
 Upstream path model: frame start pulses, tandem overhead byte with the
 multiframe on bits 7/8, and the local parity count for each frame.
 Assumes the bench changes its field inputs between frames on clk.
*/
`timescale 1ns/10ps
module tcm_frame_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] gap,
    input wire logic [3:0] code,
    input wire logic [3:0] perr,
    input wire logic mf_on,
    input wire logic zero,
    input wire logic rdi_bit,
    input wire logic odi_bit,
    output logic frame_start,
    output logic [7:0] tandem_overhead_byte,
    output logic [3:0] parity_error_count
);
    import tcm_pkg::*;
    logic [3:0] cnt_reg;
    logic [6:0] phase_reg;
    logic [1:0] mf_bits;
    logic fire;
    assign fire = (cnt_reg >= gap);
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst || fire) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= 7'h00;
        end else if (fire) begin
            phase_reg <= (phase_reg == 7'(MF_LEN - 1)) ? 7'h00 : phase_reg + 7'h01;
        end
    end
    // Last six phases carry the alignment word, bit 7 first
    always_comb begin
        mf_bits = 2'b00;
        if (phase_reg >= 7'(MF_LEN - 6)) begin
            mf_bits = (phase_reg == 7'(MF_LEN - 1)) ? 2'b10 : 2'b11;
        end
        // Receiver counts from the closing alignment frame, one phase ahead of ours
        if (phase_reg + 7'h01 == RDI_PHASE) begin
            mf_bits[0] = rdi_bit;
        end
        if (phase_reg + 7'h01 == ODI_PHASE) begin
            mf_bits[1] = odi_bit;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Lines invert between frames, so a stale byte never passes for valid
    always_ff @(posedge clk) begin
        frame_start <= fire && !rst;
        if (rst) begin
            tandem_overhead_byte <= 8'h00;
            parity_error_count <= 4'h0;
        end else if (fire) begin
            tandem_overhead_byte <= zero ? UNEQ_CODE : {code, 2'b10, mf_on ? mf_bits : 2'b00};
            parity_error_count <= perr;
        end else begin
            tandem_overhead_byte <= ~tandem_overhead_byte;
            parity_error_count <= ~parity_error_count;
        end
    end
endmodule

/* verification/testbench.sv */
/*
 Self-checking bench: AHB-Lite master, upstream frame model, queued checks.
 Assumes a zero-wait OKAY slave and registered outputs as handed over.
*/
`timescale 1ns/10ps
module testbench;
    import tcm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, frame_start;
    logic one_second = 1'b0, trace_mismatch_raw = 1'b0, server_signal_fail_in = 1'b0;
    logic mf_on = 1'b0, zero = 1'b0, rdi_bit = 1'b0, odi_bit = 1'b0, rd_ph = 1'b0, snap = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [7:0] haddr = 8'h00, tandem_overhead_byte;
    logic [3:0] gap = 4'h5, code = 4'h0, perr = 4'h0, parity_error_count;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, seed = 32'h0000_3CCF, v;
    logic trail_signal_fail, trail_signal_degrade, reported_unequipped, reported_tandem_loss;
    logic reported_trace_mismatch, reported_quality_drop, reported_server_fail;
    logic reported_remote_defect, reported_outgoing_defect, reported_incoming_alarm;
    logic near_defect_second, far_defect_second;
    logic [15:0] near_errored_block_count;
    logic [27:0] ov;
    logic [63:0] q_rd[$];
    logic [55:0] q_out[$];
    int n_fail = 0;
    int tests_run = 0;
    // Flags low to high: far, near, alarm, outgoing, remote, server, quality, trace, loss...
    assign ov = {near_errored_block_count, trail_signal_fail, trail_signal_degrade,
        reported_unequipped, reported_tandem_loss, reported_trace_mismatch,
        reported_quality_drop, reported_server_fail, reported_remote_defect,
        reported_outgoing_defect, reported_incoming_alarm, near_defect_second, far_defect_second};
    tcm_monitor #(.PM_WIDTH(16)) dut_u (
        .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .frame_start, .tandem_overhead_byte, .parity_error_count,
        .trace_mismatch_raw, .server_signal_fail_in, .one_second, .trail_signal_fail,
        .trail_signal_degrade, .reported_unequipped, .reported_tandem_loss,
        .reported_trace_mismatch, .reported_quality_drop, .reported_server_fail,
        .reported_remote_defect, .reported_outgoing_defect, .reported_incoming_alarm,
        .near_defect_second, .far_defect_second, .near_errored_block_count
    );
    tcm_frame_src src_u (
        .clk, .rst, .gap, .code, .perr, .mf_on, .zero, .rdi_bit, .odi_bit, .frame_start,
        .tandem_overhead_byte, .parity_error_count
    );
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Address and data phases kept apart; the slave's ready ends each phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        for (int i = 0; i < 16 && hreadyout !== 1'b1; i++) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !wr;
        @(posedge clk);
        for (int i = 0; i < 16 && hreadyout !== 1'b1; i++) @(posedge clk);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        q_rd.push_back({m, e});
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic chk(input logic [27:0] m, input logic [27:0] e);
        q_out.push_back({m, e});
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
        @(posedge clk);
    endtask
    // Random spacing between frames, from slow to prompt
    task automatic frames(input int n);
        seed = lfsr(seed);
        gap <= 4'h5 + {1'b0, seed[2:0]};
        repeat (n) begin
            @(posedge clk);
            for (int i = 0; i < 40 && frame_start !== 1'b1; i++) @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic sec();
        one_second <= 1'b1;
        @(posedge clk);
        one_second <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_rd(input logic [63:0] n);
        tests_run++;
        if ((hrdata & n[63:32]) !== n[31:0] || hresp !== 1'b0) begin
            n_fail++;
            $display("unexpected read at %0t: %h vs %h", $time, hrdata & n[63:32], n[31:0]);
        end
    endtask
    task automatic cmp_out(input logic [55:0] n);
        tests_run++;
        if ((ov & n[55:28]) !== n[27:0]) begin
            n_fail++;
            $display("unexpected outputs at %0t: %h vs %h", $time, ov & n[55:28], n[27:0]);
        end
    endtask
    always @(posedge clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            cmp_rd(q_rd.pop_front());
        end
        if (snap) begin
            cmp_out(q_out.pop_front());
        end
    end
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        chk(28'hFFF_FFFF, 28'h000_0000);
        rst <= 1'b0;
        rd(ADDR_CTRL, 32'hFFFF_FFFF, {24'h00_0000, CTRL_RESET});
        rd(ADDR_DEG_CFG, 32'hFFFF_FFFF, {12'h000, DEG_M_RESET, DEG_THR_RESET});
        rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
        repeat (3) begin
            seed = lfsr(seed);
            v = seed & 32'h000F_FFFF;
            bus(ADDR_DEG_CFG, 1'b1, v);
            rd(ADDR_DEG_CFG, 32'hFFFF_FFFF, v);
        end
        bus(ADDR_DEG_CFG, 1'b1, {12'h000, DEG_M_RESET, DEG_THR_RESET});
        bus(ADDR_CTRL, 1'b1, 32'h0000_003D);
        rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_003D);
        frames(3);
        chk(28'h000_0B00, 28'h000_0900);
        zero <= 1'b1;
        frames(4);
        chk(28'h000_0200, 28'h000_0000);
        frames(1);
        chk(28'h000_0B00, 28'h000_0A00);
        zero <= 1'b0;
        frames(4);
        chk(28'h000_0200, 28'h000_0200);
        frames(1);
        chk(28'h000_0300, 28'h000_0100);
        mf_on <= 1'b1;
        frames(160);
        chk(28'h000_0900, 28'h000_0000);
        rd(ADDR_STATUS, 32'h0000_0081, 32'h0000_0000);
        for (int c = 0; c < 16; c++) begin
            code <= 4'(c);
            frames(4);
            chk(28'h000_0004, {25'h000_0000, c == 15, 2'b00});
            frames(1);
            chk(28'h000_0004, {25'h000_0000, c == 14, 2'b00});
        end
        code <= 4'h0;
        rdi_bit <= 1'b1;
        odi_bit <= 1'b1;
        frames(MF_LEN * 6);
        chk(28'h000_0018, 28'h000_0018);
        sec();
        frames(1);
        perr <= 4'h3;
        frames(10);
        perr <= 4'h0;
        sec();
        chk(28'hFFF_F003, 28'h000_A001);
        rd(ADDR_PM, 32'h0003_FFFF, 32'h0002_000A);
        perr <= 4'h3;
        repeat (2) begin
            frames(2);
            sec();
        end
        chk(28'h000_0440, 28'h000_0440);
        trace_mismatch_raw <= 1'b1;
        frames(2);
        chk(28'h000_08D8, 28'h000_0880);
        bus(ADDR_CTRL, 1'b1, 32'h0000_003F);
        frames(2);
        chk(28'h000_08C0, 28'h000_0040);
        bus(ADDR_CTRL, 1'b1, 32'h0000_003D);
        server_signal_fail_in <= 1'b1;
        frames(2);
        chk(28'h000_08A0, 28'h000_0820);
        bus(ADDR_CTRL, 1'b1, 32'h0000_003C);
        repeat (3) @(posedge clk);
        chk(28'h000_0BFC, 28'h000_0800);
        final_report();
    end
endmodule
